// ==== inc/mgmt_port_regs.vh ====
`ifndef MGMT_PORT_REGS_VH
`define MGMT_PORT_REGS_VH

// bus byte offsets (one aligned word each)
`define OFS_CHA_GEN 8'h00
`define OFS_CHA_PAT 8'h04
`define OFS_CHB_GEN 8'h08
`define OFS_CHB_PAT 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_INFO 8'h18

// management-frame register numbers
`define MREG_GEN 5'h00
`define MREG_PAT 5'h0B

// general control fields
`define GEN_SEL_HI 3
`define GEN_SEL_LO 0
`define GEN_REFSEL_BIT 4
`define GEN_DPRST_BIT 14
`define GEN_PDOWN_BIT 15
`define GEN_RESET 16'h0000

// pattern control fields
`define PAT_LS_TX_BIT 6
`define PAT_LS_RX_BIT 7
`define PAT_POLY_HI 9
`define PAT_POLY_LO 8
`define PAT_HS_TX_BIT 12
`define PAT_HS_RX_BIT 13
`define POLY_7 2'h0
`define POLY_23 2'h1
`define POLY_31 2'h2
`define PAT_RESET 16'h0200

// interrupt status bits
`define IRQ_PAT_FAIL 0
`define IRQ_PDA_REL 1
`define IRQ_PDB_REL 2
`define IRQ_MGMT_WR 3
`define IRQ_WIDTH 4

// reset hold the board must give, and its cost in cycles at 4 ns
`define RST_HOLD_NS 10000
`define CLK_PERIOD_NS 4
`define RST_HOLD_CYC ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// frame timing
`define PREAMBLE_ONES 6'h20
`define STRAP_SETTLE 2'h3

`endif

// ==== design/mdio_frame_engine.v ====
`timescale 1ns/10ps
`include "mgmt_port_regs.vh"

module mdio_frame_engine (
	input wire mclk,
	input wire nrst,
	input wire mdcRise,
	input wire mdioIn,
	input wire [3:0] strapHi,
	input wire [15:0] rdData,
	output reg [4:0] regAddr,
	output reg chanSel,
	output reg wrPulse,
	output reg [15:0] wrData,
	output reg mdioOut,
	output reg mdioOe
);
	localparam PRE = 3'h0;
	localparam HDR = 3'h1;
	localparam TURN = 3'h2;
	localparam RDATA = 3'h3;
	localparam WDATA = 3'h4;

	reg [2:0] state;
	reg [5:0] ones;
	reg [3:0] cnt;
	reg [12:0] hdr;
	reg [15:0] shift;
	reg isRead;
	wire [12:0] full;
	wire opOk;
	wire match;

	// header as it stands with the bit being sampled now
	assign full = {hdr[11:0], mdioIn};
	assign opOk = (full[11:10] == 2'h2) || (full[11:10] == 2'h1);
	assign match = full[12] && opOk && (full[9:6] == strapHi);

	// one step per management clock rise; drive changes just after the rise
	always @(posedge mclk) begin
		wrPulse <= 1'b0;
		if (!nrst) begin
			state <= PRE;
			ones <= 6'h00;
			cnt <= 4'h0;
			hdr <= 13'h0000;
			shift <= 16'h0000;
			isRead <= 1'b0;
			regAddr <= 5'h00;
			chanSel <= 1'b0;
			wrData <= 16'h0000;
			mdioOut <= 1'b0;
			mdioOe <= 1'b0;
		end else if (mdcRise) begin
			case (state)
			PRE: begin
				if (mdioIn) begin
					if (ones != `PREAMBLE_ONES)
						ones <= ones + 6'h01;
				end else if (ones == `PREAMBLE_ONES) begin
					state <= HDR;
					cnt <= 4'h0;
				end else begin
					ones <= 6'h00;
				end
			end
			HDR: begin
				hdr <= full;
				cnt <= cnt + 4'h1;
				if (cnt == 4'hC) begin
					ones <= 6'h00;
					cnt <= 4'h0;
					if (match) begin
						regAddr <= full[4:0];
						chanSel <= full[5];
						isRead <= (full[11:10] == 2'h2);
						state <= TURN;
					end else begin
						state <= PRE; // foreign address: stay silent
					end
				end
			end
			TURN: begin
				cnt <= cnt + 4'h1;
				if (cnt == 4'h0) begin
					if (isRead) begin
						mdioOe <= 1'b1;
						mdioOut <= 1'b0;
						shift <= rdData;
					end
				end else begin
					cnt <= 4'h0;
					if (isRead) begin
						mdioOut <= shift[15];
						shift <= {shift[14:0], 1'b0};
						state <= RDATA;
					end else begin
						state <= WDATA;
					end
				end
			end
			RDATA: begin
				cnt <= cnt + 4'h1;
				if (cnt == 4'hF) begin
					mdioOe <= 1'b0;
					mdioOut <= 1'b0;
					state <= PRE;
				end else begin
					mdioOut <= shift[15];
					shift <= {shift[14:0], 1'b0};
				end
			end
			WDATA: begin
				cnt <= cnt + 4'h1;
				shift <= {shift[14:0], mdioIn};
				if (cnt == 4'hF) begin
					wrData <= {shift[14:0], mdioIn};
					wrPulse <= 1'b1;
					state <= PRE;
				end
			end
			default: begin
				state <= PRE;
			end
			endcase
		end
	end
endmodule // mdio_frame_engine

// ==== design/mgmt_port_addr_and_prbs_ctrl.v ====
`timescale 1ns/10ps
`include "mgmt_port_regs.vh"

// How it works
// - test pin enables all pattern generators, checkers
// - pin ORed with per-path register enables
// - polynomial defaults to 2^31-1, writable
// - ok pin high error-free, low after error
// - four-bit field picks checker routed to pin
// - ok pin driven low during reset
// - ok pin undriven when both channels power down, by both pins or both register bits
// - answer only when upper address matches straps
// - lowest address bit picks channel A/B
// - two addresses per device, sixteen devices per bus
// - register picks reference clock per channel
// - power-down pin low powers channel down
// - management stays alive in register power down

module mgmt_port_addr_and_prbs_ctrl (
	input wire mclk,
	input wire nrst,
	input wire mdc,
	input wire mdioIn,
	output wire mdioOut,
	output wire mdioOe,
	input wire [4:0] port_addr_strap,
	input wire pattern_test_enable_pin,
	input wire chan_a_powerdown_pin,
	input wire chan_b_powerdown_pin,
	input wire [15:0] checkerOk,
	output reg pattern_check_ok_pin,
	output reg patternCheckOkOe,
	output reg [7:0] patternEnable,
	output reg [3:0] polySelect,
	output reg [1:0] refClkSelect,
	output reg [1:0] chanPowerDown,
	output reg [1:0] datapathReset,
	output reg irq,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	localparam NSYNC = 9;

	wire [NSYNC-1:0] rawIn;
	wire [NSYNC-1:0] clean;
	reg [NSYNC-1:0] cleanPrev;
	reg [3:0] strapHeld;
	reg [1:0] settle;
	reg strapLoaded;
	reg [15:0] genReg [0:1];
	reg [15:0] patReg [0:1];
	reg [`IRQ_WIDTH-1:0] irqStatus;
	reg [`IRQ_WIDTH-1:0] irqMask;
	reg failLatched;
	reg [7:0] awAddr;
	reg awHeld;
	reg [31:0] wData;
	reg [3:0] wStrb;
	reg wHeld;
	wire wrFire;
	wire [4:0] mRegAddr;
	wire mChan;
	wire mWr;
	wire [15:0] mWrData;
	reg [15:0] mRdData;
	wire mdcRise;
	wire pinEn;
	wire pinPd;
	wire regPd;
	wire [3:0] sel;
	wire selEn;
	wire [`IRQ_WIDTH-1:0] events;

	// slow pins: three flops, a change counts once the last two agree
	assign rawIn = {port_addr_strap[4:1], chan_b_powerdown_pin, chan_a_powerdown_pin,
		pattern_test_enable_pin, mdioIn, mdc};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			reg s1;
			reg s2;
			reg s3;
			reg filt;
			always @(posedge mclk) begin
				s1 <= rawIn[gi];
				s2 <= s1;
				s3 <= s2;
				if (!nrst)
					filt <= s3; // follow the pin in reset: no false edge at release
				else if (s2 == s3)
					filt <= s3;
			end
			assign clean[gi] = filt;
		end
	endgenerate

	// edge history for the management clock and power-down pins
	always @(posedge mclk) begin
		if (!nrst)
			cleanPrev <= clean;
		else
			cleanPrev <= clean;
	end

	assign mdcRise = clean[0] & ~cleanPrev[0]; // management clock rise
	assign pinEn = clean[2];
	// straps are caught after release, once the filter has settled
	always @(posedge mclk) begin
		if (!nrst) begin
			settle <= 2'h0;
			strapLoaded <= 1'b0;
			strapHeld <= 4'h0;
		end else if (!strapLoaded) begin
			settle <= settle + 2'h1;
			if (settle == `STRAP_SETTLE) begin
				strapHeld <= clean[8:5];
				strapLoaded <= 1'b1;
			end
		end
	end

	// frame engine; strap bit 0 never enters the match
	mdio_frame_engine u_frame (
		.mclk(mclk),
		.nrst(nrst & strapLoaded),
		.mdcRise(mdcRise),
		.mdioIn(clean[1]),
		.strapHi(strapHeld),
		.rdData(mRdData),
		.regAddr(mRegAddr),
		.chanSel(mChan),
		.wrPulse(mWr),
		.wrData(mWrData),
		.mdioOut(mdioOut),
		.mdioOe(mdioOe)
	);

	// frame read data; frames keep working in register power down
	always @* begin
		case (mRegAddr)
		`MREG_GEN: mRdData = genReg[mChan];
		`MREG_PAT: mRdData = patReg[mChan];
		default: mRdData = 16'h0000;
		endcase
	end

	assign wrFire = awHeld & wHeld & ~s_axi_bvalid;

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
		end
	endfunction

	// per-channel registers; a bus write landing with a frame write wins
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
			wire busGen;
			wire busPat;
			wire frmGen;
			wire frmPat;
			reg [15:0] next_gen;
			assign busGen = wrFire && awAddr == (gi ? `OFS_CHB_GEN : `OFS_CHA_GEN);
			assign busPat = wrFire && awAddr == (gi ? `OFS_CHB_PAT : `OFS_CHA_PAT);
			assign frmGen = mWr && mChan == gi && mRegAddr == `MREG_GEN;
			assign frmPat = mWr && mChan == gi && mRegAddr == `MREG_PAT;
			always @* begin
				next_gen = genReg[gi];
				if (frmGen)
					next_gen = mWrData;
				if (busGen)
					next_gen = merge16(genReg[gi], wData, wStrb);
			end
			always @(posedge mclk) begin
				if (!nrst) begin
					genReg[gi] <= `GEN_RESET;
					patReg[gi] <= `PAT_RESET;
					datapathReset[gi] <= 1'b0;
					patternEnable[gi*4+3:gi*4] <= 4'h0;
					polySelect[gi*2+1:gi*2] <= `POLY_31;
					refClkSelect[gi] <= 1'b0;
					chanPowerDown[gi] <= 1'b0;
				end else begin
					// datapath reset bit is a pulse and never reads back
					genReg[gi] <= next_gen & ~(16'h0001 << `GEN_DPRST_BIT);
					datapathReset[gi] <= (busGen | frmGen) & next_gen[`GEN_DPRST_BIT];
					if (frmPat)
						patReg[gi] <= mWrData;
					if (busPat)
						patReg[gi] <= merge16(patReg[gi], wData, wStrb);
					patternEnable[gi*4+3:gi*4] <= {4{pinEn}} |
						{patReg[gi][`PAT_HS_RX_BIT], patReg[gi][`PAT_HS_TX_BIT],
						patReg[gi][`PAT_LS_RX_BIT], patReg[gi][`PAT_LS_TX_BIT]};
					polySelect[gi*2+1:gi*2] <= patReg[gi][`PAT_POLY_HI:`PAT_POLY_LO];
					refClkSelect[gi] <= genReg[gi][`GEN_REFSEL_BIT];
					chanPowerDown[gi] <= ~clean[3+gi] | genReg[gi][`GEN_PDOWN_BIT];
				end
			end
		end
	endgenerate

	// selector: bit3 channel, bit2 low-speed side, bits1:0 lane
	assign sel = genReg[0][`GEN_SEL_HI:`GEN_SEL_LO];
	assign selEn = sel[2] ? patternEnable[sel[3]*4] | patternEnable[{sel[3], 2'h1}] :
		patternEnable[{sel[3], 2'h3}] | patternEnable[{sel[3], 2'h2}];
	assign pinPd = ~clean[3] & ~clean[4];
	assign regPd = genReg[0][`GEN_PDOWN_BIT] & genReg[1][`GEN_PDOWN_BIT];

	// status pin; a failure sticks until testing on the path stops
	always @(posedge mclk) begin
		if (!nrst) begin
			pattern_check_ok_pin <= 1'b0;
			patternCheckOkOe <= 1'b1;
			failLatched <= 1'b0;
		end else if (pinPd | regPd) begin
			pattern_check_ok_pin <= 1'b0;
			patternCheckOkOe <= 1'b0;
		end else if (!selEn) begin
			pattern_check_ok_pin <= 1'b0;
			patternCheckOkOe <= 1'b1;
			failLatched <= 1'b0;
		end else begin
			patternCheckOkOe <= 1'b1;
			if (!checkerOk[sel]) begin
				failLatched <= 1'b1;
				pattern_check_ok_pin <= 1'b0;
			end else begin
				pattern_check_ok_pin <= ~failLatched;
			end
		end
	end

	assign events[`IRQ_PAT_FAIL] = selEn & ~pinPd & ~regPd & ~checkerOk[sel] & ~failLatched;
	assign events[`IRQ_PDA_REL] = clean[3] & ~cleanPrev[3];
	assign events[`IRQ_PDB_REL] = clean[4] & ~cleanPrev[4];
	assign events[`IRQ_MGMT_WR] = mWr;

	// sticky status: a new event beats a write-one clear in the same cycle
	always @(posedge mclk) begin
		if (!nrst) begin
			irqStatus <= {`IRQ_WIDTH{1'b0}};
			irqMask <= {`IRQ_WIDTH{1'b0}};
			irq <= 1'b0;
		end else begin
			if (wrFire && awAddr == `OFS_IRQ_STATUS && wStrb[0])
				irqStatus <= (irqStatus & ~wData[`IRQ_WIDTH-1:0]) | events;
			else
				irqStatus <= irqStatus | events;
			if (wrFire && awAddr == `OFS_IRQ_MASK && wStrb[0])
				irqMask <= wData[`IRQ_WIDTH-1:0];
			irq <= |(irqStatus & irqMask);
		end
	end

	// bus write side: address and data taken in either order, one at a time
	always @(posedge mclk) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end else begin
			s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr > `OFS_INFO) ? 2'h2 : 2'h0;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld <= 1'b0;
				wHeld <= 1'b0;
			end
		end
	end

	// bus read side; unmapped words answer zero with a slave error
	always @(posedge mclk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case ({s_axi_araddr[7:2], 2'h0})
				`OFS_CHA_GEN: s_axi_rdata <= {16'h0000, genReg[0]};
				`OFS_CHA_PAT: s_axi_rdata <= {16'h0000, patReg[0]};
				`OFS_CHB_GEN: s_axi_rdata <= {16'h0000, genReg[1]};
				`OFS_CHB_PAT: s_axi_rdata <= {16'h0000, patReg[1]};
				`OFS_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irqStatus};
				`OFS_IRQ_MASK: s_axi_rdata <= {28'h0000000, irqMask};
				`OFS_INFO: s_axi_rdata <= {16'h0000, patternEnable, strapHeld,
					pattern_check_ok_pin, patternCheckOkOe, clean[4:3]};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // mgmt_port_addr_and_prbs_ctrl

// ==== tb/mgmt_port_asserts.sv ====
`timescale 1ns/10ps
module mgmt_port_asserts (
	input wire mclk,
	input wire nrst,
	input wire pattern_test_enable_pin,
	input wire chan_a_powerdown_pin,
	input wire chan_b_powerdown_pin,
	input wire pattern_check_ok_pin,
	input wire patternCheckOkOe,
	input wire [7:0] patternEnable,
	input wire [3:0] polySelect,
	input wire [1:0] chanPowerDown
);
	default clocking cb @(posedge mclk); endclocking
	// three cycles fully enabled, so a low pin is a real latched error
	sequence allOn;
		(nrst && patternEnable == 8'hFF) [*3];
	endsequence
	sequence bothDown;
		(nrst && !chan_a_powerdown_pin && !chan_b_powerdown_pin) [*8];
	endsequence
	// reset checks carry no disable, they watch reset itself
	a_reset_pin_low: assert property (!nrst |=> !pattern_check_ok_pin && patternCheckOkOe)
		else $error("ok pin not driven low in reset");
	a_poly_default: assert property (!nrst |=> polySelect == 4'hA)
		else $error("polynomial not 31 after reset");
	a_pin_pd_float: assert property (disable iff (!nrst) bothDown |=> !patternCheckOkOe)
		else $error("ok pin driven in pin power down");
	a_test_pin_on: assert property (disable iff (!nrst)
		(nrst && pattern_test_enable_pin) [*8] |=> patternEnable == 8'hFF)
		else $error("test pin did not enable all paths");
	a_ok_latched: assert property (disable iff (!nrst) allOn ##0
		(patternCheckOkOe && !pattern_check_ok_pin) |=> !pattern_check_ok_pin || !patternCheckOkOe)
		else $error("error indication not held");
	a_disabled_low: assert property (disable iff (!nrst)
		(nrst && patternEnable == 8'h00) [*2] |-> !pattern_check_ok_pin)
		else $error("ok pin high with paths disabled");
	a_chan_a_down: assert property (disable iff (!nrst)
		(nrst && !chan_a_powerdown_pin) [*8] |=> chanPowerDown[0])
		else $error("channel A not powered down");
	a_chan_b_down: assert property (disable iff (!nrst)
		(nrst && !chan_b_powerdown_pin) [*8] |=> chanPowerDown[1])
		else $error("channel B not powered down");
endmodule // mgmt_port_asserts

bind mgmt_port_addr_and_prbs_ctrl mgmt_port_asserts chk (.mclk, .nrst, .pattern_test_enable_pin,
	.chan_a_powerdown_pin, .chan_b_powerdown_pin, .pattern_check_ok_pin, .patternCheckOkOe,
	.patternEnable, .polySelect, .chanPowerDown);

// ==== tb/mdio_ctrl_model.sv ====
`timescale 1ns/10ps
module mdio_ctrl_model (
	input wire mdioOut,
	input wire mdioOe,
	output reg mdc,
	output wire mdioIn
);
	reg drv;
	reg dOut;
	// pulled-up wire: released by both sides it reads high
	assign mdioIn = mdioOe ? mdioOut : (drv ? dOut : 1'h1);
	initial begin
		mdc = 1'h0;
		drv = 1'h0;
		dOut = 1'h1;
	end
	// one frame; the clock runs only inside it, 48 ns period
	task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd,
		output [15:0] rd);
		reg [63:0] bits;
		integer i;
		begin
			bits = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
			rd = 16'h0000;
			for (i = 63; i >= 0; i = i - 1) begin
				drv = !(op == 2'h2 && i < 18);
				dOut = bits[i];
				#24 mdc = 1'h1;
				if (i < 16) rd[i] = mdioIn;
				#24 mdc = 1'h0;
			end
			drv = 1'h0;
			#200;
		end
	endtask
endmodule // mdio_ctrl_model

// ==== tb/mgmt_port_addr_and_prbs_ctrl_test.sv ====
`timescale 1ns/10ps
`include "mgmt_port_regs.vh"
module mgmt_port_addr_and_prbs_ctrl_test;
	reg mclk, nrst, pattern_test_enable_pin, chan_a_powerdown_pin, chan_b_powerdown_pin;
	reg [4:0] port_addr_strap;
	reg [15:0] checkerOk, fd;
	reg [7:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata, rv, mdl [0:3];
	reg [31:0] seed = 32'h47542999;
	reg [3:0] s_axi_wstrb;
	reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire mdc, mdioIn, mdioOut, mdioOe, pattern_check_ok_pin, patternCheckOkOe, irq;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [7:0] patternEnable;
	wire [3:0] polySelect;
	wire [1:0] refClkSelect, chanPowerDown, datapathReset, s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	integer n_fail = 0, checked = 0, cyc = 0, i;
	reg [1:0] dpSeen = 2'h0;
	mgmt_port_addr_and_prbs_ctrl dut (.mclk, .nrst, .mdc, .mdioIn, .mdioOut, .mdioOe,
		.port_addr_strap, .pattern_test_enable_pin, .chan_a_powerdown_pin,
		.chan_b_powerdown_pin, .checkerOk, .pattern_check_ok_pin, .patternCheckOkOe,
		.patternEnable, .polySelect, .refClkSelect, .chanPowerDown, .datapathReset, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	mdio_ctrl_model ctl (.mdioOut, .mdioOe, .mdc, .mdioIn);
	always #2 mclk = ~mclk;
	// datapath reset is a one-cycle pulse: remember that it passed
	always @(posedge mclk) begin
		if (nrst) dpSeen <= dpSeen | datapathReset;
	end
	// hang guard, well above the expected run length
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail = n_fail + 1;
			wrap_up;
		end
	end
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			checked = checked + 1;
			if (e !== g) begin
				n_fail = n_fail + 1;
				$display("MISMATCH %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wrap_up;
		begin
			if (n_fail == 0 && checked > 0) $display("Simulation passed");
			else $display("Simulation failed");
			$finish;
		end
	endtask
	// write; each channel is dropped at its own handshake, the model follows
	task axw(input [7:0] a, input [31:0] d);
		reg aw, w;
		begin
			aw = 1'h1;
			w = 1'h1;
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= 4'hF;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			while (aw || w) begin
				@(posedge mclk);
				if (s_axi_awready === 1'h1) aw = 1'h0;
				if (s_axi_wready === 1'h1) w = 1'h0;
				s_axi_awvalid <= aw;
				s_axi_wvalid <= w;
			end
			while (s_axi_bvalid !== 1'h1) @(posedge mclk);
			chk("bresp", (a > 8'h18) ? 2'h2 : 2'h0, s_axi_bresp);
			s_axi_bready <= 1'h0;
			if (a < 8'h10) mdl[a[3:2]] = d & (a[2] ? 32'h33C0 : 32'h801F);
			@(posedge mclk);
		end
	endtask
	task axr(input [7:0] a, output [31:0] d);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			@(posedge mclk);
			while (s_axi_arready !== 1'h1) @(posedge mclk);
			s_axi_arvalid <= 1'h0;
			while (s_axi_rvalid !== 1'h1) @(posedge mclk);
			d = s_axi_rdata;
			chk("rresp", (a > 8'h18) ? 2'h2 : 2'h0, s_axi_rresp);
			s_axi_rready <= 1'h0;
			@(posedge mclk);
		end
	endtask
	task rdc(input [7:0] a);
		begin
			axr(a, rv);
			chk("reg", (a < 8'h10) ? mdl[a[3:2]] : 32'h0, rv);
		end
	endtask
	// pins pass three sync flops before they act
	task waitc;
		repeat (12) @(posedge mclk);
	endtask
	initial begin
		mclk = 1'h0;
		nrst = 1'h0;
		pattern_test_enable_pin = 1'h0;
		chan_a_powerdown_pin = 1'h1;
		chan_b_powerdown_pin = 1'h1;
		port_addr_strap = 5'h16; // lowest strap grounded
		checkerOk = 16'hFFFF;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		mdl[0] = 32'h0;
		mdl[1] = 32'h200;
		mdl[2] = 32'h0;
		mdl[3] = 32'h200;
		repeat (`RST_HOLD_CYC) @(posedge mclk);
		nrst <= 1'h1;
		@(posedge mclk);
		for (i = 0; i < 20; i = i + 4) rdc(i);
		axr(8'h18, rv);
		chk("strap", 32'hB0, rv & 32'hF0);
		rdc(8'h1C);
		axw(8'h1C, 32'hFFFFFFFF);
		// random path enables, every polynomial code, both channels
		for (i = 0; i < 6; i = i + 1) begin
			seed = xs(seed);
			axw({4'h0, i[0], 3'h4}, (seed & 32'h30C0) | ((i >> 1) << 8));
			rdc({4'h0, i[0], 3'h4});
			chk("enable", {mdl[3][13:12], mdl[3][7:6], mdl[1][13:12], mdl[1][7:6]},
				patternEnable);
			chk("poly", {mdl[3][9:8], mdl[1][9:8]}, polySelect);
		end
		axw(8'h04, 32'h0);
		axw(8'h0C, 32'h0);
		axw(8'h14, 32'h1);
		// each select: a foreign error is ignored, an own one latches low
		for (i = 0; i < 16; i = i + 1) begin
			axw(8'h00, i);
			checkerOk <= ~(16'h1 << ((i + 1) % 16));
			pattern_test_enable_pin <= 1'h1;
			waitc;
			chk("enable", 8'hFF, patternEnable);
			chk("okpin", 1'h1, pattern_check_ok_pin);
			checkerOk <= ~(16'h1 << i);
			@(posedge mclk);
			checkerOk <= 16'hFFFF;
			waitc;
			chk("okpin", 1'h0, pattern_check_ok_pin);
			chk("irq", 1'h1, irq);
			pattern_test_enable_pin <= 1'h0;
			axw(8'h10, 32'h1);
			waitc;
			chk("irq", 1'h0, irq);
		end
		// pin power down floats the pin; release events stay masked
		chan_a_powerdown_pin <= 1'h0;
		chan_b_powerdown_pin <= 1'h0;
		waitc;
		chk("okoe", 1'h0, patternCheckOkOe);
		chk("pd", 2'h3, chanPowerDown);
		chan_a_powerdown_pin <= 1'h1;
		chan_b_powerdown_pin <= 1'h1;
		waitc;
		chk("irq", 1'h0, irq);
		axr(8'h10, rv);
		chk("status", 32'h6, rv & 32'h6);
		// after release software restarts each datapath, one channel at a time
		axw(8'h00, 32'h4000);
		chk("dpreset", 2'h1, dpSeen);
		axw(8'h08, 32'h4000);
		chk("dpreset", 2'h3, dpSeen);
		// register power down: pin floats, frames still answered
		axw(8'h00, 32'h8000);
		axw(8'h08, 32'h8000);
		waitc;
		chk("okoe", 1'h0, patternCheckOkOe);
		ctl.frame(2'h2, {port_addr_strap[4:1], 1'h1}, `MREG_GEN, 16'h0, fd);
		@(posedge mclk);
		chk("frame rd", mdl[2], fd);
		axw(8'h00, 32'h10);
		axw(8'h08, 32'h0);
		chk("refclk", 2'h1, refClkSelect);
		// frame writes to A, to B, then to a foreign device
		for (i = 0; i < 3; i = i + 1) begin
			seed = xs(seed);
			fd = seed[15:0] & 16'h30C0;
			ctl.frame(2'h1, {port_addr_strap[4:1] ^ ((i == 2) ? 4'h1 : 4'h0), i[0]},
				`MREG_PAT, fd, rv[15:0]);
			@(posedge mclk);
			if (i < 2) mdl[{i[0], 1'h1}] = fd;
			rdc({4'h0, i[0], 3'h4});
		end
		ctl.frame(2'h2, {~port_addr_strap[4:1], 1'h0}, `MREG_PAT, 16'h0, fd);
		@(posedge mclk);
		chk("foreign rd", 16'hFFFF, fd);
		// straps moved after capture count only from the next reset
		port_addr_strap <= 5'h0A;
		pattern_test_enable_pin <= 1'h1;
		waitc;
		chk("okpin", 1'h1, pattern_check_ok_pin);
		axr(8'h18, rv);
		chk("strap", 32'hB0, rv & 32'hF0);
		nrst <= 1'h0;
		repeat (4) @(posedge mclk);
		chk("okpin", 1'h0, pattern_check_ok_pin);
		chk("okoe", 1'h1, patternCheckOkOe);
		nrst <= 1'h1;
		waitc;
		axr(8'h18, rv);
		chk("strap", 32'h50, rv & 32'hF0);
		chk("poly", 4'hA, polySelect);
		wrap_up;
	end
endmodule // mgmt_port_addr_and_prbs_ctrl_test
